// ==== iuvfr_top.sv ====
// Purpose: Decides run, shut down or retry on an input undervoltage fault.
// Assumes: PMBus command decoder on clk delivers byte writes and clears.
// Notes: Fault comparator and remote on/off pin are asynchronous inputs.
//        Every interval is a down-count of the unit length times two to the delay code.
//        A setting write leaves the retry budget alone; only a clear while latched, an off or a reset reloads it.
`timescale 1ns/1ps
`include "iuvfr_params.svh"
module iuvfr_top
  import iuvfr_pkg::*;
#(
  parameter int UNIT_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg_wr_en,
  input wire logic [7:0] cfg_wr_data,
  output logic [7:0] cfg_rd_data,
  input wire logic [UNIT_W-1:0] time_unit_cycles,
  input wire logic uv_fault_pin,
  input wire logic control_pin_on,
  input wire logic operation_on,
  input wire logic clear_faults,
  input wire logic status_clear,
  input wire logic other_fault_off,
  output logic output_enable,
  output logic uv_fault_status,
  output logic [2:0] retries_left,
  output logic retrying
);

  typedef struct packed {
    iuvfr_state_type state;  // Controller state
    iuvfr_cfg_type cfg;      // Response setting byte
    logic [2:0] budget;      // Restarts still allowed
    logic status;            // Sticky fault status bit
    logic out_en;            // Output enable to power stage
    logic uv_s1;             // Fault synchroniser stage 1
    logic uv_s2;             // Fault synchroniser stage 2
    logic ctl_s1;            // Control pin stage 1
    logic ctl_s2;            // Control pin stage 2
  } iuvfr_top_type;

  iuvfr_top_type s_reg;
  iuvfr_top_type s_next;
  logic timer_start;   // Load the interval timer
  logic timer_done;    // Interval elapsed
  logic run_cmd;       // Output commanded on
  logic fault;         // Synchronised fault level
  logic clear_evt;     // Any software clear

  // Reset image of the setting; the budget starts from its retry field
  localparam iuvfr_cfg_type CFG_RST = iuvfr_cfg_type'(`IUVFR_CFG_RESET);

  // Budget is spent unless the code asks for endless retries
  // Code seven never runs out, so the budget is not even looked at
  function automatic logic can_retry(input logic [2:0] code, input logic [2:0] left);
    can_retry = (code == `IUVFR_RETRY_FOREVER) || (left != `IUVFR_RETRY_NONE);
  endfunction

  // ============================================================
  // Interval timer
  // ============================================================
  // Counts in clock cycles; the unit length is supplied from outside
  iuvfr_timer #(
    .UNIT_W(UNIT_W)
  ) u_timer (
    .clk(clk),
    .reset(reset),
    .start(timer_start),
    .exp_code(s_reg.cfg.delay),
    .unit_cycles(time_unit_cycles),
    .done(timer_done)
  );

  // Output is commanded on only while both the pin and the command agree
  assign run_cmd = s_reg.ctl_s2 & operation_on;
  // Second synchroniser stage only; the raw pin is never read by logic
  assign fault = s_reg.uv_s2;
  // Either clear source ends a latched episode and drops the status bit
  assign clear_evt = clear_faults | status_clear;

  // ============================================================
  // Next-state logic
  // ============================================================
  always_comb begin
    s_next = s_reg;
    timer_start = 1'b0;
    // Two-flop synchronisers; stage 1 feeds only stage 2
    s_next.uv_s1 = uv_fault_pin;
    s_next.uv_s2 = s_reg.uv_s1;
    s_next.ctl_s1 = control_pin_on;
    s_next.ctl_s2 = s_reg.ctl_s1;
    // Whole-byte write of the setting
    if (cfg_wr_en) begin
      s_next.cfg = iuvfr_cfg_type'(cfg_wr_data);
    end
    // Sticky status: a fault in the clear cycle still sets it
    if (clear_evt) begin
      s_next.status = 1'b0;
    end
    if (fault) begin
      s_next.status = 1'b1;
    end
    case (s_reg.state)
      IUVFR_OFF: begin
        // Held off; turning on again starts a fresh episode
        s_next.out_en = 1'b0;
        s_next.budget = s_reg.cfg.retry;
        if (run_cmd) begin
          s_next.state = IUVFR_RUN;
          s_next.out_en = 1'b1;
        end
      end
      IUVFR_RUN: begin
        // Running; the response type decides what a fault does
        s_next.out_en = 1'b1;
        if (fault) begin
          case (s_reg.cfg.resp)
            `IUVFR_RESP_IGNORE: begin
              // Keep going; the status bit still records the fault
              s_next.state = IUVFR_RUN;
            end
            `IUVFR_RESP_DELAY: begin
              // Grace delay first; the retry field is consulted when it ends
              timer_start = 1'b1;
              s_next.state = IUVFR_DELAY_RUN;
            end
            `IUVFR_RESP_DISABLE: begin
              // Off at once; wait to retry while budget remains or the retry code asks for endless retries
              s_next.out_en = 1'b0;
              if (can_retry(s_reg.cfg.retry, s_reg.budget)) begin
                timer_start = 1'b1;
                s_next.state = IUVFR_RETRY_WAIT;
              end else begin
                s_next.state = IUVFR_LATCHED;
              end
            end
            default: begin
              // Latch off; only a clear or an off-then-on restarts
              s_next.out_en = 1'b0;
              s_next.state = IUVFR_LATCHED;
            end
          endcase
        end
      end
      IUVFR_DELAY_RUN: begin
        // Keep regulating through the grace delay
        s_next.out_en = 1'b1;
        if (timer_done) begin
          // Fault gone when the delay ends: carry on as if nothing happened
          if (!fault) begin
            s_next.state = IUVFR_RUN;
          end else if (can_retry(s_reg.cfg.retry, s_reg.budget)) begin
            s_next.out_en = 1'b0;
            timer_start = 1'b1;
            s_next.state = IUVFR_RETRY_WAIT;
          end else begin
            s_next.out_en = 1'b0;
            s_next.state = IUVFR_LATCHED;
          end
        end
      end
      IUVFR_RETRY_WAIT: begin
        // Output off; the wait lasts one interval plus one cycle of timer end latency
        s_next.out_en = 1'b0;
        if (timer_done) begin
          // Endless retries leave the budget alone, so it can never wrap
          if (s_reg.cfg.retry != `IUVFR_RETRY_FOREVER) begin
            s_next.budget = s_reg.budget - 3'(`IUVFR_RETRY_ONE);
          end
          s_next.out_en = 1'b1;
          s_next.state = IUVFR_RUN;
        end
      end
      default: begin
        // Latched off until a clear while commanded on
        s_next.out_en = 1'b0;
        if (clear_evt) begin
          s_next.budget = s_reg.cfg.retry;
          if (run_cmd) begin
            s_next.state = IUVFR_RUN;
            s_next.out_en = 1'b1;
          end else begin
            s_next.state = IUVFR_OFF;
          end
        end
      end
    endcase
    // Another fault stops retries; commanded off overrides everything
    if (other_fault_off) begin
      s_next.out_en = 1'b0;
      s_next.state = IUVFR_LATCHED;
    end
    if (!run_cmd) begin
      s_next.out_en = 1'b0;
      s_next.budget = s_reg.cfg.retry;
      s_next.state = IUVFR_OFF;
    end
  end

  // ============================================================
  // State register
  // ============================================================
  // Asynchronous reset loads constants only; the setting returns to ignore
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.state <= IUVFR_OFF;
      s_reg.cfg <= CFG_RST;
      s_reg.budget <= CFG_RST.retry;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs come straight from the state register
  // The retry flag is a decode of the state register and settles each cycle
  assign cfg_rd_data = s_reg.cfg;
  assign output_enable = s_reg.out_en;
  assign uv_fault_status = s_reg.status;
  assign retries_left = s_reg.budget;
  assign retrying = (s_reg.state == IUVFR_RETRY_WAIT);

endmodule // iuvfr_top

// ==== iuvfr_params.svh ====
// Purpose: Constants for the input undervoltage fault response controller.
// Assumes: Included by its bare name from the top and timer design modules.
// Notes: Bit positions and codes of the one-byte response setting.
`ifndef IUVFR_PARAMS_SVH
`define IUVFR_PARAMS_SVH

// ============================================================
// Response setting layout and codes
// ============================================================
`define IUVFR_CFG_RESET 8'h00
`define IUVFR_RESP_IGNORE 2'h0
`define IUVFR_RESP_DELAY 2'h1
`define IUVFR_RESP_DISABLE 2'h2
`define IUVFR_RESP_LATCH 2'h3
`define IUVFR_RETRY_NONE 3'h0
`define IUVFR_RETRY_FOREVER 3'h7
`define IUVFR_RETRY_ONE 3'h1

// ============================================================
// Timer constants
// ============================================================
`define IUVFR_EXP_PAD 7
`define IUVFR_CNT_DONE 1

`endif

// ==== iuvfr_pkg.sv ====
// Purpose: Types shared by the fault response controller files.
// Assumes: The constants header sits in the same folder.
// Notes: Field order of the config struct matches the byte, MSB first.
package iuvfr_pkg;

  // ============================================================
  // Response setting carrier
  // ============================================================
  typedef struct packed {
    logic [1:0] resp;  // Response type
    logic [2:0] retry; // Retry count code
    logic [2:0] delay; // Delay exponent
  } iuvfr_cfg_type;

  // Controller states
  typedef enum logic [2:0] {
    IUVFR_OFF,
    IUVFR_RUN,
    IUVFR_DELAY_RUN,
    IUVFR_RETRY_WAIT,
    IUVFR_LATCHED
  } iuvfr_state_type;

endpackage

// ==== iuvfr_timer.sv ====
// Purpose: Down-counter that times one delay of 2**exp time units.
// Assumes: Time unit given in clock cycles, same clock as the user.
// Notes: A unit of zero is treated as one cycle so the timer always ends.
`timescale 1ns/1ps
`include "iuvfr_params.svh"
module iuvfr_timer
  import iuvfr_pkg::*;
#(
  parameter int UNIT_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [2:0] exp_code,
  input wire logic [UNIT_W-1:0] unit_cycles,
  output logic done
);

  localparam int CNT_W = UNIT_W + `IUVFR_EXP_PAD;

  typedef struct packed {
    logic busy;              // Counting in progress
    logic [CNT_W-1:0] cnt;   // Cycles left
    logic done;              // One-cycle end pulse
  } iuvfr_tmr_type;

  iuvfr_tmr_type s_reg;
  iuvfr_tmr_type s_next;
  logic [UNIT_W-1:0] unit_safe;

  // ============================================================
  // Next-state logic
  // ============================================================
  // Start wins over a running count so a fresh interval restarts cleanly
  always_comb begin
    unit_safe = (unit_cycles == '0) ? UNIT_W'(1) : unit_cycles;
    s_next = s_reg;
    s_next.done = 1'b0;
    if (start) begin
      s_next.busy = 1'b1;
      s_next.cnt = CNT_W'({{`IUVFR_EXP_PAD{1'b0}}, unit_safe} << exp_code);
    end else if (s_reg.busy) begin
      if (s_reg.cnt == CNT_W'(`IUVFR_CNT_DONE)) begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt - CNT_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign done = s_reg.done;

endmodule // iuvfr_timer

// ==== iuvfr_properties.sv ====
// Purpose: Port checks of the undervoltage fault response controller.
// Assumes: Bound to iuvfr_top; the bench holds the control pin on.
// Notes: Retry spacing figures are measured by the bench instead.
`timescale 1ns/1ps
module iuvfr_properties
  import iuvfr_pkg::*;
#(
  parameter int UNIT_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg_wr_en,
  input wire logic [7:0] cfg_wr_data,
  input wire logic [7:0] cfg_rd_data,
  input wire logic [UNIT_W-1:0] time_unit_cycles,
  input wire logic uv_fault_pin,
  input wire logic control_pin_on,
  input wire logic operation_on,
  input wire logic clear_faults,
  input wire logic status_clear,
  input wire logic other_fault_off,
  input wire logic output_enable,
  input wire logic uv_fault_status,
  input wire logic [2:0] retries_left,
  input wire logic retrying
);
  // ==========================================
  // One clock domain, so shared clocking
  // ==========================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_cfg;
    cfg_wr_en |=> cfg_rd_data == $past(cfg_wr_data);
  endproperty
  a_cfg: assert property (p_cfg) else $error("setting readback wrong");
  property p_ign;
    $rose(uv_fault_status) && cfg_rd_data[7:6] == 2'h0 && output_enable && operation_on
      && !other_fault_off |=> output_enable [*3];
  endproperty
  a_ign: assert property (p_ign) else $error("ignored fault stopped output");
  property p_dly;
    $rose(uv_fault_status) && cfg_rd_data[7:6] == 2'h1 && output_enable && operation_on
      && !other_fault_off |=> output_enable;
  endproperty
  a_dly: assert property (p_dly) else $error("output dropped before delay");
  // Types 10 and 11 both shut down at once
  property p_dis;
    $rose(uv_fault_status) && cfg_rd_data[7] |-> ##[0:1] !output_enable;
  endproperty
  a_dis: assert property (p_dis) else $error("output not disabled on fault");
  property p_lat;
    !output_enable && !retrying && uv_fault_status && cfg_rd_data[7:6] == 2'h3 && !clear_faults
      && !status_clear && operation_on && $past(operation_on) |=> !output_enable;
  endproperty
  a_lat: assert property (p_lat) else $error("latched output came back");
  property p_none;
    $rose(retrying) |-> cfg_rd_data[5:3] != 3'h0;
  endproperty
  a_none: assert property (p_none) else $error("retry with zero budget");
  property p_bud;
    $rose(output_enable) && $past(retrying) && cfg_rd_data[5:3] != 3'h7
      |-> retries_left == $past(retries_left) - 3'h1;
  endproperty
  a_bud: assert property (p_bud) else $error("budget not spent on attempt");
  property p_off;
    !operation_on || other_fault_off |=> !output_enable;
  endproperty
  a_off: assert property (p_off) else $error("output on while commanded off");
endmodule // iuvfr_properties

bind iuvfr_top iuvfr_properties #(.UNIT_W(UNIT_W)) chk_u (.*);

// ==== iuvfr_host.sv ====
// Purpose: Host model that writes the setting byte and clears faults.
// Assumes: Requests change 1 ns after a rising edge.
// Notes: The data lines carry junk when no write is under way.
`timescale 1ns/1ps
module iuvfr_host (
  input wire logic clk,
  output logic cfg_wr_en,
  output logic [7:0] cfg_wr_data,
  output logic clear_faults,
  output logic status_clear
);
  // Idle values at time zero
  initial begin
    cfg_wr_en = 1'h0;
    cfg_wr_data = 8'h5a;
    clear_faults = 1'h0;
    status_clear = 1'h0;
  end
  // Whole byte in one strobe, then inverted so stale data never matches
  task automatic write_cfg(input logic [7:0] b);
    @(posedge clk);
    #1 cfg_wr_en = 1'h1;
    cfg_wr_data = b;
    @(posedge clk);
    #1 cfg_wr_en = 1'h0;
    cfg_wr_data = ~b;
  endtask
  // One-cycle clear pulse, either kind
  task automatic clear(input logic all_faults);
    @(posedge clk);
    #1 clear_faults = all_faults;
    status_clear = !all_faults;
    @(posedge clk);
    #1 clear_faults = 1'h0;
    status_clear = 1'h0;
  endtask
endmodule // iuvfr_host

// ==== input_uv_fault_response_test.sv ====
// Purpose: Self-checking bench of the fault response controller.
// Assumes: Unit of 2 cycles keeps the retry intervals short.
// Notes: Retry wait spans the interval plus one cycle of timer end latency.
`timescale 1ns/1ps
module input_uv_fault_response_test;
  import iuvfr_pkg::*;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic [15:0] time_unit_cycles = 16'h0002;
  logic uv_fault_pin = 1'h0;
  logic control_pin_on = 1'h1;
  logic operation_on = 1'h0;
  logic other_fault_off = 1'h0;
  logic cfg_wr_en, clear_faults, status_clear, output_enable, uv_fault_status, retrying;
  logic [7:0] cfg_wr_data, cfg_rd_data;
  logic [2:0] retries_left;
  int fail_count, check_count, cyc, n, r;
  always #10 clk = ~clk;
  iuvfr_host host_u (.clk(clk), .cfg_wr_en(cfg_wr_en), .cfg_wr_data(cfg_wr_data),
    .clear_faults(clear_faults), .status_clear(status_clear));
  iuvfr_top dut_u (.clk(clk), .reset(reset), .cfg_wr_en(cfg_wr_en), .cfg_wr_data(cfg_wr_data),
    .cfg_rd_data(cfg_rd_data), .time_unit_cycles(time_unit_cycles), .uv_fault_pin(uv_fault_pin),
    .control_pin_on(control_pin_on), .operation_on(operation_on), .clear_faults(clear_faults),
    .status_clear(status_clear), .other_fault_off(other_fault_off),
    .output_enable(output_enable), .uv_fault_status(uv_fault_status),
    .retries_left(retries_left), .retrying(retrying));
  // ==========================================
  // Helpers
  // ==========================================
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Counts output restarts and cycles spent waiting to retry
  task automatic watch(input int k);
    logic prev;
    n = 0;
    r = 0;
    prev = output_enable;
    repeat (k) begin
      tick(1);
      if (output_enable && !prev) n++;
      if (retrying) r++;
      prev = output_enable;
    end
  endtask
  // Off then on gives a clean episode with the new setting
  task automatic fresh(input logic [7:0] b);
    uv_fault_pin = 1'h0;
    operation_on = 1'h0;
    tick(4);
    host_u.clear(1'h1);
    check("status cleared", uv_fault_status, 1'h0);
    host_u.write_cfg(b);
    check("setting", cfg_rd_data, b);
    operation_on = 1'h1;
    tick(6);
    check("budget", retries_left, b[5:3]);
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  // ==========================================
  // Tests
  // ==========================================
  initial begin
    tick(5);
    reset = 1'h0;
    check("reset setting", cfg_rd_data, 8'h00);
    fresh(8'h00);
    uv_fault_pin = 1'h1;
    tick(20);
    check("ignore", output_enable, 1'h1);
    host_u.clear(1'h0);
    check("status set wins", uv_fault_status, 1'h1);
    $display("ignore test done");
    for (int c = 0; c < 7; c++) begin
      fresh({2'h2, c[2:0], 3'h0});
      uv_fault_pin = 1'h1;
      watch(150);
      check("attempts", n, c);
      check("stays off", output_enable, 1'h0);
    end
    fresh(8'hb8);
    uv_fault_pin = 1'h1;
    watch(150);
    check("endless", n > 6, 1'h1);
    operation_on = 1'h0;
    tick(2);
    check("commanded off", output_enable, 1'h0);
    $display("retry count test done");
    for (int u = 2; u < 5; u += 2) begin
      for (int d = 0; d < 3; d++) begin
        time_unit_cycles = u[15:0];
        fresh({2'h2, 3'h1, d[2:0]});
        uv_fault_pin = 1'h1;
        watch(100);
        check("spacing", r, (u << d) + 1);
      end
    end
    time_unit_cycles = 16'h0002;
    $display("spacing test done");
    for (int m = 0; m < 4; m++) begin
      fresh(8'hc8);
      uv_fault_pin = 1'h1;
      tick(6);
      uv_fault_pin = 1'h0;
      tick(6);
      check("latched", output_enable, 1'h0);
      check("status", uv_fault_status, 1'h1);
      if (m < 2) host_u.clear(m[0]);
      else if (m == 2) fresh(8'hc8);
      else begin
        reset = 1'h1;
        tick(2);
        reset = 1'h0;
      end
      tick(6);
      check("cleared", output_enable, 1'h1);
      check("status after clear", uv_fault_status, 1'h0);
    end
    $display("latch test done");
    fresh(8'h43);
    uv_fault_pin = 1'h1;
    tick(5);
    uv_fault_pin = 1'h0;
    watch(30);
    check("brief fault", {n[0], output_enable}, 2'h1);
    uv_fault_pin = 1'h1;
    tick(8);
    check("in delay", output_enable, 1'h1);
    tick(20);
    check("after delay", output_enable, 1'h0);
    fresh(8'h48);
    uv_fault_pin = 1'h1;
    watch(60);
    check("retry after delay", {n[3:0], output_enable}, 8'h02);
    fresh(8'h00);
    other_fault_off = 1'h1;
    tick(2);
    check("other fault", output_enable, 1'h0);
    other_fault_off = 1'h0;
    $display("delay and shutdown test done");
    give_verdict();
  end
endmodule // input_uv_fault_response_test
